// file: mvic_ctrl.sv
// vectored interrupt controller: flags, enables, priority and vector call
// assumes the core pushes push_pc_o on irq_call_o and loads pc on pc_load_o
//
// Contract
// - master enable low blocks every source
// - events set flags; enable gates the request
// - accept pushes next pc, loads vector
// - return pops saved pc and resumes
// - servicing clears the master enable
// - blocked requests keep their flags pending
// - software re-setting master enable allows nesting
// - no acknowledge while the stack is full
// - requests serviced on the next phase tick
// - highest first: ext_a 04, ext_b 08, timer_a 0c
// - timer b 10, serial 14, shared 18
// - sub-sources keep flags, set shared flag
// - shared service clears only the shared flag
// - primary register bit layout, bit 7 zero
// - secondary register bit layout, bits 7,3 zero
// - flags active high, enables high, reset zero
// - periph pin needs three enables set
// - dedicated service clears its own flag
// - edge select: off, rise, fall, both
`timescale 1ns/1ns
module mvic_ctrl import mvic_pkg::*; #(
  parameter int PCW = 12 // program counter width
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reg_addr_i, // register index
  input wire logic reg_wr_i, // write strobe
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic [1:0] ext_a_edge_sel_i,
  input wire logic [1:0] ext_b_edge_sel_i,
  input wire logic timer_a_ovf_i,
  input wire logic timer_b_ovf_i,
  input wire logic serial_done_i,
  input wire logic [NSUB-1:0] sub_event_i,
  input wire logic [NSUB-1:0] sub_enable_i,
  input wire logic [NSUB-1:0] sub_clear_i,
  output logic [NSUB-1:0] sub_flag_o,
  input wire logic phase_two_tick_i,
  input wire logic stack_full_i,
  input wire logic [PCW-1:0] pc_next_i,
  input wire logic return_from_irq_i,
  input wire logic [PCW-1:0] pop_pc_i,
  output logic irq_call_o,
  output logic [PCW-1:0] push_pc_o,
  output logic pop_o,
  output logic pc_load_o,
  output logic [PCW-1:0] pc_load_value_o
);
  // -------------------------------------------------------------------
  // state and next values
  // -------------------------------------------------------------------
  logic global_irq_enable; // master enable
  logic [NSRC-1:0] flags; // request flags in source order
  logic [NSRC-1:0] enables; // individual enables in source order
  logic [NSUB-1:0] sub_flags; // multi-function sub-source flags
  logic next_gie;
  logic [NSRC-1:0] next_flags;
  logic [NSRC-1:0] next_enables;
  logic [NSUB-1:0] next_sub_flags;
  logic [7:0] next_rdata;
  logic next_call;
  logic next_pop;
  logic next_load;
  logic [PCW-1:0] next_load_value;
  logic [PCW-1:0] next_push;
  // -------------------------------------------------------------------
  // events and arbitration
  // -------------------------------------------------------------------
  logic ext_a_event;
  logic ext_b_event;
  logic [NSRC-1:0] events; // hardware set strobes
  logic [NSUB-1:0] sub_gated; // sub events whose own enable is set
  logic [NSRC-1:0] pending; // flag and enable both high
  logic [NSRC-1:0] grant; // one-hot winner
  logic [7:0] win_vector;
  logic accept; // interrupt taken this cycle
  logic [7:0] primary_view;
  logic [7:0] secondary_view;

  // external pin edge detectors
  mvic_pin_edge u_edge_a (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .pin_i(ext_irq_pin_a_i),
    .edge_sel_i(ext_a_edge_sel_i),
    .event_o(ext_a_event)
  );
  mvic_pin_edge u_edge_b (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .pin_i(ext_irq_pin_b_i),
    .edge_sel_i(ext_b_edge_sel_i),
    .event_o(ext_b_event)
  );

  // peripheral pin also needs its own enable; shared enable gates later
  assign sub_gated = sub_event_i & sub_enable_i;
  assign events = {|sub_gated, serial_done_i, timer_b_ovf_i, timer_a_ovf_i,
    ext_b_event, ext_a_event};
  assign pending = flags & enables;

  // fixed priority winner
  mvic_prio_enc u_prio (
    .pending_i(pending),
    .grant_o(grant),
    .vector_o(win_vector)
  );

  // take on the tick only with master enable, room on stack, no return
  assign accept = phase_two_tick_i & global_irq_enable & (|pending) & ~stack_full_i
    & ~return_from_irq_i;

  // register views, unimplemented bits low
  assign primary_view = {1'b0, flags[SRC_TIMER_A], flags[SRC_EXT_B], flags[SRC_EXT_A],
    enables[SRC_TIMER_A], enables[SRC_EXT_B], enables[SRC_EXT_A], global_irq_enable};
  assign secondary_view = {1'b0, flags[SRC_SHARED], flags[SRC_SERIAL], flags[SRC_TIMER_B],
    1'b0, enables[SRC_SHARED], enables[SRC_SERIAL], enables[SRC_TIMER_B]};

  // -------------------------------------------------------------------
  // next-state logic for flags, enables and core handshake
  // -------------------------------------------------------------------
  always_comb begin
    next_gie = global_irq_enable;
    next_flags = flags;
    next_enables = enables;
    // software writes come first, hardware overrides follow
    if (reg_wr_i && reg_addr_i == REG_PRIMARY) begin
      next_gie = reg_wdata_i[P_GIE];
      next_enables[SRC_EXT_A] = reg_wdata_i[P_EXT_A_EN];
      next_enables[SRC_EXT_B] = reg_wdata_i[P_EXT_B_EN];
      next_enables[SRC_TIMER_A] = reg_wdata_i[P_TIMER_A_EN];
      next_flags[SRC_EXT_A] = reg_wdata_i[P_EXT_A_FLAG];
      next_flags[SRC_EXT_B] = reg_wdata_i[P_EXT_B_FLAG];
      next_flags[SRC_TIMER_A] = reg_wdata_i[P_TIMER_A_FLAG];
    end else if (reg_wr_i) begin
      next_enables[SRC_TIMER_B] = reg_wdata_i[S_TIMER_B_EN];
      next_enables[SRC_SERIAL] = reg_wdata_i[S_SERIAL_EN];
      next_enables[SRC_SHARED] = reg_wdata_i[S_SHARED_EN];
      next_flags[SRC_TIMER_B] = reg_wdata_i[S_TIMER_B_FLAG];
      next_flags[SRC_SERIAL] = reg_wdata_i[S_SERIAL_FLAG];
      next_flags[SRC_SHARED] = reg_wdata_i[S_SHARED_FLAG];
    end
    // servicing drops the winner flag and the master enable
    if (accept) begin
      next_gie = 1'b0;
      next_flags = next_flags & ~grant;
    end
    // a new event beats any clear in the same cycle
    next_flags = next_flags | events;
  end

  // sub-source flags: only software clears them, set wins
  always_comb begin
    // every sub event is recorded; only the shared flag waits on the sub enable
    next_sub_flags = (sub_flags & ~sub_clear_i) | sub_event_i;
  end

  // core handshake and read data
  always_comb begin
    next_call = accept;
    next_push = pc_next_i;
    next_pop = return_from_irq_i;
    next_load = accept | return_from_irq_i;
    if (accept) begin
      next_load_value = {{(PCW-8){1'b0}}, win_vector};
    end else begin
      next_load_value = pop_pc_i;
    end
    next_rdata = (reg_addr_i == REG_PRIMARY) ? primary_view : secondary_view;
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      global_irq_enable <= 1'b0;
      flags <= '0;
      enables <= '0;
      sub_flags <= '0;
      reg_rdata_o <= REG_RESET;
      irq_call_o <= 1'b0;
      push_pc_o <= '0;
      pop_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_load_value_o <= '0;
    end else begin
      global_irq_enable <= next_gie;
      flags <= next_flags;
      enables <= next_enables;
      sub_flags <= next_sub_flags;
      reg_rdata_o <= next_rdata;
      irq_call_o <= next_call;
      push_pc_o <= next_push;
      pop_o <= next_pop;
      pc_load_o <= next_load;
      pc_load_value_o <= next_load_value;
    end
  end

  assign sub_flag_o = sub_flags;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence s_accept;
    phase_two_tick_i && global_irq_enable && (|pending) && !stack_full_i && !return_from_irq_i;
  endsequence

  sequence s_call_vec(logic [7:0] v);
    irq_call_o && pc_load_o && pc_load_value_o == {{(PCW-8){1'b0}}, v};
  endsequence

  property p_gie_blocks;
    @(posedge clock_i) disable iff (reset_i) !global_irq_enable |=> !irq_call_o;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("call while master enable low");

  property p_stack_full;
    @(posedge clock_i) disable iff (reset_i) stack_full_i |=> !irq_call_o;
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("call while stack full");

  property p_accept_call;
    @(posedge clock_i) disable iff (reset_i) s_accept |=> irq_call_o && push_pc_o == $past(pc_next_i)
      && !global_irq_enable;
  endproperty
  a_accept_call: assert property (p_accept_call) else $error("accept did not call");

  property p_no_tick_no_call;
    @(posedge clock_i) disable iff (reset_i) !phase_two_tick_i |=> !irq_call_o;
  endproperty
  a_no_tick_no_call: assert property (p_no_tick_no_call) else $error("call off the tick");

  property p_vec_top;
    @(posedge clock_i) disable iff (reset_i) s_accept and pending[SRC_EXT_A] |=> s_call_vec(VEC_EXT_A);
  endproperty
  a_vec_top: assert property (p_vec_top) else $error("ext a vector wrong");

  property p_vec_shared;
    @(posedge clock_i) disable iff (reset_i) s_accept and pending == 6'h20 && sub_clear_i == 6'h00
      |=> s_call_vec(VEC_SHARED) ##0 (sub_flags & $past(sub_flags)) == $past(sub_flags);
  endproperty
  a_vec_shared: assert property (p_vec_shared) else $error("shared service wrong");

  property p_timer_clear;
    @(posedge clock_i) disable iff (reset_i) s_accept and grant[SRC_TIMER_A] && !timer_a_ovf_i
      |=> !flags[SRC_TIMER_A];
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer flag not cleared");

  property p_flag_holds;
    @(posedge clock_i) disable iff (reset_i) flags[SRC_SERIAL] && !accept && !reg_wr_i
      |=> flags[SRC_SERIAL];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("pending flag lost");

  property p_return;
    @(posedge clock_i) disable iff (reset_i) return_from_irq_i |=> pop_o && pc_load_o && !irq_call_o
      && pc_load_value_o == $past(pop_pc_i);
  endproperty
  a_return: assert property (p_return) else $error("return did not pop");

  property p_event_sets;
    @(posedge clock_i) disable iff (reset_i) timer_a_ovf_i |=> flags[SRC_TIMER_A];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set its flag");

  property p_write_lands;
    @(posedge clock_i) disable iff (reset_i) reg_wr_i && reg_addr_i == REG_PRIMARY && reg_wdata_i[P_GIE]
      && !accept |=> global_irq_enable;
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("master enable write lost");

  property p_shared_gated;
    @(posedge clock_i) disable iff (reset_i) !flags[SRC_SHARED] && !(|(sub_event_i & sub_enable_i))
      && !reg_wr_i |=> !flags[SRC_SHARED];
  endproperty
  a_shared_gated: assert property (p_shared_gated) else $error("shared flag without sub enable");

  property p_sub_kept;
    @(posedge clock_i) disable iff (reset_i) sub_flags[SUB_PERIPH] && !sub_clear_i[SUB_PERIPH]
      |=> sub_flags[SUB_PERIPH];
  endproperty
  a_sub_kept: assert property (p_sub_kept) else $error("sub flag lost without clear");

  property p_read_view;
    @(posedge clock_i) disable iff (reset_i) reg_addr_i == REG_SECONDARY |=> reg_rdata_o[7] == 1'b0
      && reg_rdata_o[3] == 1'b0;
  endproperty
  a_read_view: assert property (p_read_view) else $error("unimplemented bit read high");

  property p_edge_off;
    @(posedge clock_i) disable iff (reset_i) ext_a_edge_sel_i == EDGE_OFF && !flags[SRC_EXT_A] && !reg_wr_i
      |=> !flags[SRC_EXT_A];
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("pin flag set while edge select off");
endmodule // mvic_ctrl

// file: mvic_pkg.sv
// constants shared by the vectored interrupt controller files
// assumes an 8-bit register port and a core that pushes and pops the pc
package mvic_pkg;
  // -------------------------------------------------------------------
  // register indexes on the data memory port
  // -------------------------------------------------------------------
  localparam logic REG_PRIMARY = 1'b0; // primary control register
  localparam logic REG_SECONDARY = 1'b1; // secondary control register
  localparam logic [7:0] REG_RESET = 8'h00; // every implemented bit resets low
  // -------------------------------------------------------------------
  // primary register bit positions
  // -------------------------------------------------------------------
  localparam int P_GIE = 0;
  localparam int P_EXT_A_EN = 1;
  localparam int P_EXT_B_EN = 2;
  localparam int P_TIMER_A_EN = 3;
  localparam int P_EXT_A_FLAG = 4;
  localparam int P_EXT_B_FLAG = 5;
  localparam int P_TIMER_A_FLAG = 6;
  // -------------------------------------------------------------------
  // secondary register bit positions
  // -------------------------------------------------------------------
  localparam int S_TIMER_B_EN = 0;
  localparam int S_SERIAL_EN = 1;
  localparam int S_SHARED_EN = 2;
  localparam int S_TIMER_B_FLAG = 4;
  localparam int S_SERIAL_FLAG = 5;
  localparam int S_SHARED_FLAG = 6;
  // -------------------------------------------------------------------
  // source slots, index 0 is the highest priority
  // -------------------------------------------------------------------
  localparam int NSRC = 6;
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_TIMER_A = 2;
  localparam int SRC_TIMER_B = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_SHARED = 5;
  localparam int NSUB = 6; // converter, time base, periph pin, comparator, nvm, low voltage
  localparam int SUB_PERIPH = 2; // peripheral pin sub-source slot
  // -------------------------------------------------------------------
  // vectors in source order and edge select codes
  // -------------------------------------------------------------------
  localparam logic [7:0] VEC_EXT_A = 8'h04;
  localparam logic [7:0] VEC_EXT_B = 8'h08;
  localparam logic [7:0] VEC_TIMER_A = 8'h0c;
  localparam logic [7:0] VEC_TIMER_B = 8'h10;
  localparam logic [7:0] VEC_SERIAL = 8'h14;
  localparam logic [7:0] VEC_SHARED = 8'h18;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// file: mvic_pin_edge.sv
// external pin synchroniser and selectable edge detector
// assumes the pin is asynchronous to clock_i and the select is static-ish
`timescale 1ns/1ns
module mvic_pin_edge import mvic_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  output logic event_o
);
  // -------------------------------------------------------------------
  // two-flop synchroniser plus history flop
  // -------------------------------------------------------------------
  logic sync_a; // first stage, read only by sync_b
  logic sync_b; // settled pin level
  logic prev; // level one cycle earlier
  logic next_event; // qualified edge this cycle

  // edge qualification by the two-bit select
  always_comb begin
    unique case (edge_sel_i)
      EDGE_OFF: next_event = 1'b0;
      EDGE_RISE: next_event = sync_b & ~prev;
      EDGE_FALL: next_event = ~sync_b & prev;
      EDGE_BOTH: next_event = sync_b ^ prev;
    endcase
  end

  // register the stages
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign event_o = next_event;
endmodule // mvic_pin_edge

// file: mvic_prio_enc.sv
// fixed priority picker: lowest pending index wins, with its vector
// assumes pending is already gated by the individual enables
`timescale 1ns/1ns
module mvic_prio_enc import mvic_pkg::*; (
  input wire logic [NSRC-1:0] pending_i,
  output logic [NSRC-1:0] grant_o,
  output logic [7:0] vector_o
);
  // -------------------------------------------------------------------
  // vector table in priority order
  // -------------------------------------------------------------------
  localparam logic [7:0] VEC_TABLE [NSRC] = '{VEC_EXT_A, VEC_EXT_B, VEC_TIMER_A,
    VEC_TIMER_B, VEC_SERIAL, VEC_SHARED};

  // scan from lowest priority upward so the highest one is left standing
  always_comb begin
    grant_o = '0;
    vector_o = 8'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending_i[i]) begin
        grant_o = '0;
        grant_o[i] = 1'b1;
        vector_o = VEC_TABLE[i];
      end
    end
  end
endmodule // mvic_prio_enc

// file: mvic_core_model.sv
// core side model: program counter and return stack for the controller
// assumes one-cycle irq call, pop and pc load pulses from the controller
`timescale 1ns/1ns
module mvic_core_model #(
  parameter int PCW = 12, // program counter width
  parameter int DEPTH = 2 // return stack depth
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ret_cmd_i, // bench asks for a return instruction
  input wire logic irq_call_i,
  input wire logic [PCW-1:0] push_pc_i,
  input wire logic pop_i,
  input wire logic pc_load_i,
  input wire logic [PCW-1:0] pc_load_value_i,
  output logic [PCW-1:0] pc_next_o,
  output logic stack_full_o,
  output logic return_from_irq_o,
  output logic [PCW-1:0] pop_pc_o
);
  // ------------------------------------------------------------
  // pc and stack state
  // ------------------------------------------------------------
  logic [PCW-1:0] pc; // address of the next instruction
  logic [PCW-1:0] stack [DEPTH]; // saved return addresses
  int sp; // entries in use
  // pc steps each cycle unless loaded; stack follows push and pop
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pc <= '0;
      sp <= 0;
    end else begin
      if (pc_load_i) begin
        pc <= pc_load_value_i;
      end else begin
        pc <= pc + 1'b1;
      end
      if (irq_call_i && sp < DEPTH) begin
        stack[sp] <= push_pc_i;
        sp <= sp + 1;
      end else if (pop_i && sp > 0) begin
        sp <= sp - 1;
      end
    end
  end
  // outputs; an empty stack shows a moving pattern, not the old top
  assign pc_next_o = pc;
  assign stack_full_o = (sp == DEPTH);
  assign return_from_irq_o = ret_cmd_i && (sp != 0);
  assign pop_pc_o = (sp > 0) ? stack[sp-1] : ~pc;
endmodule // mvic_core_model

// file: mcu_vectored_interrupt_ctrl_tb_top.sv
// self-checking bench for the vectored interrupt controller
// assumes mvic_pkg and the core model are compiled first
`timescale 1ns/1ns
module mcu_vectored_interrupt_ctrl_tb_top;
  import mvic_pkg::*;
  localparam int PCW = 12;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_addr_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic ext_irq_pin_a_i = 1'b0;
  logic ext_irq_pin_b_i = 1'b0;
  logic [1:0] edge_sel = 2'h0; // same select for both pins
  logic [8:0] evt = 9'h000; // timer a, timer b, serial, six sub events
  logic [NSUB-1:0] sub_enable_i = 6'h04;
  logic [NSUB-1:0] sub_clear_i = 6'h00;
  logic [NSUB-1:0] sub_flag_o;
  logic phase_two_tick_i = 1'b0;
  logic stack_full_i, return_from_irq_i, irq_call_o, pop_o, pc_load_o;
  logic [PCW-1:0] pc_next_i, pop_pc_i, push_pc_o, pc_load_value_o;
  logic ret_cmd = 1'b0; // asks the core model for a return
  logic [PCW-1:0] saved [$]; // expected return addresses
  logic [7:0] vecs [6] = '{VEC_EXT_A, VEC_EXT_B, VEC_TIMER_A, VEC_TIMER_B, VEC_SERIAL, VEC_SHARED};
  logic [7:0] p, s; // expected register contents
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 clock_i = ~clock_i;
  // ------------------------------------------------------------
  // design and core model
  // ------------------------------------------------------------
  mvic_ctrl #(.PCW(PCW)) dut_u (.clock_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .ext_irq_pin_a_i, .ext_irq_pin_b_i, .ext_a_edge_sel_i(edge_sel), .ext_b_edge_sel_i(edge_sel),
    .timer_a_ovf_i(evt[0]), .timer_b_ovf_i(evt[1]), .serial_done_i(evt[2]), .sub_event_i(evt[8:3]),
    .sub_enable_i, .sub_clear_i, .sub_flag_o, .phase_two_tick_i, .stack_full_i, .pc_next_i,
    .return_from_irq_i, .pop_pc_i, .irq_call_o, .push_pc_o, .pop_o, .pc_load_o, .pc_load_value_o);
  mvic_core_model #(.PCW(PCW), .DEPTH(2)) core_u (.clock_i, .reset_i, .ret_cmd_i(ret_cmd),
    .irq_call_i(irq_call_o), .push_pc_i(push_pc_o), .pop_i(pop_o), .pc_load_i(pc_load_o),
    .pc_load_value_i(pc_load_value_o), .pc_next_o(pc_next_i), .stack_full_o(stack_full_i),
    .return_from_irq_o(return_from_irq_i), .pop_pc_o(pop_pc_i));
  // ------------------------------------------------------------
  // compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wr_i <= 1'b1;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    @(posedge clock_i);
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clock_i);
    evt <= m;
    @(posedge clock_i);
    evt <= 9'h000;
  endtask
  // one phase tick; a call must carry the vector and the pc of that edge
  task automatic tick(input logic call, input logic [7:0] vec);
    logic [PCW-1:0] pc;
    @(posedge clock_i);
    phase_two_tick_i <= 1'b1;
    #1 pc = pc_next_i;
    @(posedge clock_i);
    phase_two_tick_i <= 1'b0;
    #1 chk({irq_call_o, pc_load_o}, {call, call});
    if (call) begin
      chk(pc_load_value_o, vec);
      chk(push_pc_o, pc);
      saved.push_back(pc);
    end
  endtask
  // return instruction; the popped pc must be reloaded
  task automatic ret();
    @(posedge clock_i);
    ret_cmd <= 1'b1;
    @(posedge clock_i);
    ret_cmd <= 1'b0;
    #1 chk({pop_o, pc_load_o}, 2'h3);
    chk(pc_load_value_o, saved.pop_back());
  endtask
  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(REG_PRIMARY, REG_RESET);
    rd(REG_SECONDARY, REG_RESET);
    wr(REG_PRIMARY, 8'hff);
    rd(REG_PRIMARY, 8'h7f);
    wr(REG_PRIMARY, 8'h01);
    wr(REG_SECONDARY, 8'hff);
    rd(REG_SECONDARY, 8'h77);
    wr(REG_SECONDARY, 8'h00);
    // flag without its enable raises nothing
    pulse(9'h002);
    rd(REG_SECONDARY, 8'h10);
    tick(1'b0, 8'h00);
    // master enable low blocks, flag is kept, late tick serves it
    wr(REG_PRIMARY, 8'h08);
    pulse(9'h001);
    tick(1'b0, 8'h00);
    rd(REG_PRIMARY, 8'h48);
    wr(REG_PRIMARY, 8'h49);
    repeat (3) @(posedge clock_i);
    #1 chk(irq_call_o, 1'b0);
    tick(1'b1, VEC_TIMER_A);
    rd(REG_PRIMARY, 8'h08);
    ret();
    // shared source needs sub, shared and master enables
    wr(REG_SECONDARY, 8'h04);
    wr(REG_PRIMARY, 8'h01);
    sub_enable_i <= 6'h00;
    pulse(9'h020);
    rd(REG_SECONDARY, 8'h04);
    tick(1'b0, 8'h00);
    chk(sub_flag_o, 6'h04);
    @(posedge clock_i);
    sub_enable_i <= 6'h04;
    sub_clear_i <= 6'h3f;
    @(posedge clock_i);
    sub_clear_i <= 6'h00;
    // all six pending: served strictly in priority order
    wr(REG_SECONDARY, 8'h37);
    pulse(9'h020);
    #1 chk(sub_flag_o, 6'h04);
    wr(REG_PRIMARY, 8'h7f);
    p = 8'h7e;
    s = 8'h77;
    for (int i = 0; i < 6; i++) begin
      tick(1'b1, vecs[i]);
      if (i < 3) p[P_EXT_A_FLAG + i] = 1'b0;
      else s[S_TIMER_B_FLAG + i - 3] = 1'b0;
      rd(REG_PRIMARY, p);
      rd(REG_SECONDARY, s);
      wr(REG_PRIMARY, p | 8'h01);
      ret();
    end
    chk(sub_flag_o, 6'h04);
    @(posedge clock_i);
    sub_clear_i <= 6'h04;
    @(posedge clock_i);
    sub_clear_i <= 6'h00;
    @(posedge clock_i);
    #1 chk(sub_flag_o, 6'h00);
    // nesting fills the two-deep stack, then acceptance waits
    wr(REG_PRIMARY, 8'h49);
    tick(1'b1, VEC_TIMER_A);
    wr(REG_PRIMARY, 8'h49);
    tick(1'b1, VEC_TIMER_A);
    wr(REG_PRIMARY, 8'h49);
    tick(1'b0, 8'h00);
    rd(REG_PRIMARY, 8'h49);
    ret();
    tick(1'b1, VEC_TIMER_A);
    ret();
    ret();
    // every edge select code against a rising and a falling pin
    for (int c = 0; c < 4; c++) begin
      @(posedge clock_i);
      edge_sel <= 2'(c);
      wr(REG_PRIMARY, 8'h00);
      for (int e = 0; e < 2; e++) begin
        ext_irq_pin_a_i <= (e == 0);
        ext_irq_pin_b_i <= (e == 0);
        repeat (5) @(posedge clock_i);
        rd(REG_PRIMARY, (c >> e) & 1 ? 8'h30 : 8'h00);
        wr(REG_PRIMARY, 8'h00);
      end
    end
    test_done();
  end
endmodule // mcu_vectored_interrupt_ctrl_tb_top
